// ===== rtl/fscs_store.sv
// Fuse store with latched active copy, signature row and trim autoload.
`timescale 1ns/1ps
`default_nettype none
`include "fscs_params.svh"
module fscs_store #(
    // Identification bytes; values are arbitrary.
    parameter logic [7:0] SIG_BYTE0 = 8'hA5,
    parameter logic [7:0] SIG_BYTE1 = 8'h5A,
    parameter logic [7:0] SIG_BYTE2 = 8'h3C,
    // Calibration values for 1, 2, 4 and 8MHz.
    parameter logic [7:0] CAL_1MHZ = 8'h80,
    parameter logic [7:0] CAL_2MHZ = 8'h81,
    parameter logic [7:0] CAL_4MHZ = 8'h82,
    parameter logic [7:0] CAL_8MHZ = 8'h83
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Mode control
    input wire logic prog_ser,
    input wire logic prog_par,
    // Programmer access
    input wire logic fuse_wr,
    input wire logic [1:0] fuse_sel,
    input wire logic [7:0] fuse_wdata,
    input wire logic chip_erase,
    input wire logic lock_wr,
    input wire logic [7:0] lock_wdata,
    input wire logic [1:0] rd_addr,
    output logic [7:0] fuse_rdata,
    output logic [7:0] sig_rdata,
    output logic [7:0] cal_rdata,
    // Software trim access
    input wire logic trim_wr,
    input wire logic [7:0] trim_wdata,
    output logic [7:0] rc_trim_reg,
    // Active configuration
    output logic legacy_compat_sel,
    output logic watchdog_forced_on,
    output logic onchip_debug_en,
    output logic scan_port_en,
    output logic serial_download_en,
    output logic osc_option,
    output logic eeprom_preserve,
    output logic boot_size_hi,
    output logic boot_size_lo,
    output logic reset_vector_sel,
    output logic brownout_level,
    output logic brownout_on,
    output logic startup_sel_hi,
    output logic startup_sel_lo,
    output logic [3:0] clk_source_sel,
    output logic rc_1mhz_sel,
    output logic sleep_clk_keep,
    output logic mem_lock_first,
    // Address geometry
    input wire logic [15:0] flash_pc,
    input wire logic [11:0] eeprom_addr,
    output logic [6:0] flash_word_in_page,
    output logic [8:0] flash_page_sel,
    output logic [2:0] eeprom_byte_in_page,
    output logic [8:0] eeprom_page_sel
);
    typedef struct packed {
        fscs_pkg::fscs_fuse_t cells;
        fscs_pkg::fscs_fuse_t active;
        logic [7:0] lock;
        logic [7:0] trim;
        fscs_pkg::fscs_mode_t mode;
        logic pwr_up;
        logic [1:0] ser_sync;
        logic [1:0] par_sync;
        logic [7:0] fuse_rd;
        logic [7:0] sig_rd;
        logic [7:0] cal_rd;
    } fscs_state_t;

    fscs_state_t st_ff;
    fscs_state_t nxt_st;
    logic in_ser;
    logic in_par;
    logic [7:0] wval;

    function automatic logic [7:0] sig_byte(input logic [1:0] a);
        case (a)
            2'h0: sig_byte = SIG_BYTE0;
            2'h1: sig_byte = SIG_BYTE1;
            2'h2: sig_byte = SIG_BYTE2;
            default: sig_byte = 8'hFF;
        endcase
    endfunction

    function automatic logic [7:0] cal_byte(input logic [1:0] a);
        case (a)
            2'h0: cal_byte = CAL_1MHZ;
            2'h1: cal_byte = CAL_2MHZ;
            2'h2: cal_byte = CAL_4MHZ;
            default: cal_byte = CAL_8MHZ;
        endcase
    endfunction

    assign in_ser = st_ff.ser_sync[1];
    assign in_par = st_ff.par_sync[1];

    always_comb
    begin
        nxt_st = st_ff;
        wval = fuse_wdata;
        nxt_st.ser_sync = {st_ff.ser_sync[0], prog_ser};
        nxt_st.par_sync = {st_ff.par_sync[0], prog_par};
        nxt_st.pwr_up = 1'b0;
        if (st_ff.pwr_up)
        begin
            nxt_st.active = st_ff.cells;
        end
        case (st_ff.mode)
            fscs_pkg::FSCS_NORMAL:
            begin
                if (in_ser || in_par)
                begin
                    nxt_st.active = st_ff.cells;
                    nxt_st.mode = in_par ? fscs_pkg::FSCS_PROG_PAR : fscs_pkg::FSCS_PROG_SER;
                end
            end
            fscs_pkg::FSCS_PROG_SER, fscs_pkg::FSCS_PROG_PAR:
            begin
                if (!in_ser && !in_par)
                begin
                    nxt_st.active = st_ff.cells;
                    nxt_st.mode = fscs_pkg::FSCS_NORMAL;
                end
                else if (fuse_wr && st_ff.lock[0])
                begin
                    case (fuse_sel)
                        `FSCS_SEL_EXT:
                        begin
                            nxt_st.cells.ext = wval | `FSCS_EXT_UNUSED_MASK;
                        end
                        `FSCS_SEL_HIGH:
                        begin
                            if (st_ff.mode == fscs_pkg::FSCS_PROG_SER)
                            begin
                                wval[`FSCS_BIT_SERIAL_DL] = st_ff.cells.high[`FSCS_BIT_SERIAL_DL];
                            end
                            nxt_st.cells.high = wval;
                            nxt_st.active.high[`FSCS_BIT_EE_PRESERVE] = wval[`FSCS_BIT_EE_PRESERVE];
                        end
                        `FSCS_SEL_LOW:
                        begin
                            nxt_st.cells.low = wval;
                        end
                        default:
                        begin
                            nxt_st.cells = st_ff.cells;
                        end
                    endcase
                end
                if (chip_erase && (in_ser || in_par))
                begin
                    nxt_st.lock = 8'hFF;
                end
                else if (lock_wr && (in_ser || in_par))
                begin
                    // Lock bits only move toward programmed.
                    nxt_st.lock = st_ff.lock & lock_wdata;
                end
            end
            default:
            begin
                nxt_st.mode = fscs_pkg::FSCS_NORMAL;
            end
        endcase
        case (fuse_sel)
            `FSCS_SEL_EXT: nxt_st.fuse_rd = st_ff.cells.ext;
            `FSCS_SEL_HIGH: nxt_st.fuse_rd = st_ff.cells.high;
            `FSCS_SEL_LOW: nxt_st.fuse_rd = st_ff.cells.low;
            default: nxt_st.fuse_rd = st_ff.lock;
        endcase
        nxt_st.sig_rd = sig_byte(rd_addr);
        nxt_st.cal_rd = cal_byte(rd_addr);
        if (trim_wr)
        begin
            nxt_st.trim = trim_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff.cells <= {`FSCS_EXT_RESET, `FSCS_HIGH_RESET, `FSCS_LOW_RESET};
            st_ff.active <= {`FSCS_EXT_RESET, `FSCS_HIGH_RESET, `FSCS_LOW_RESET};
            st_ff.lock <= 8'hFF;
            st_ff.trim <= CAL_1MHZ;
            st_ff.mode <= fscs_pkg::FSCS_NORMAL;
            st_ff.pwr_up <= 1'b1;
            st_ff.ser_sync <= 2'h0;
            st_ff.par_sync <= 2'h0;
            st_ff.fuse_rd <= 8'hFF;
            st_ff.sig_rd <= 8'h00;
            st_ff.cal_rd <= 8'h00;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign legacy_compat_sel = st_ff.active.ext[`FSCS_BIT_LEGACY_COMPAT];
    assign watchdog_forced_on = st_ff.active.ext[`FSCS_BIT_WATCHDOG_ON];
    assign onchip_debug_en = st_ff.active.high[`FSCS_BIT_DEBUG_EN];
    assign scan_port_en = st_ff.active.high[`FSCS_BIT_SCAN_EN];
    assign serial_download_en = st_ff.active.high[`FSCS_BIT_SERIAL_DL];
    assign osc_option = st_ff.active.high[`FSCS_BIT_OSC_OPT];
    assign eeprom_preserve = st_ff.active.high[`FSCS_BIT_EE_PRESERVE];
    assign boot_size_hi = st_ff.active.high[`FSCS_BIT_BOOT_HI];
    assign boot_size_lo = st_ff.active.high[`FSCS_BIT_BOOT_LO];
    assign reset_vector_sel = st_ff.active.high[`FSCS_BIT_RESET_VEC];
    assign brownout_level = st_ff.active.low[`FSCS_BIT_BO_LEVEL];
    assign brownout_on = st_ff.active.low[`FSCS_BIT_BO_ON];
    assign startup_sel_hi = st_ff.active.low[`FSCS_SUT_HI];
    assign startup_sel_lo = st_ff.active.low[`FSCS_SUT_LO];
    assign clk_source_sel = st_ff.active.low[`FSCS_CKSEL_HI:`FSCS_CKSEL_LO];
    assign rc_1mhz_sel = (clk_source_sel == `FSCS_CKSEL_RC_1MHZ);
    assign sleep_clk_keep = ~onchip_debug_en;
    assign mem_lock_first = ~st_ff.lock[0];
    assign fuse_rdata = st_ff.fuse_rd;
    assign sig_rdata = st_ff.sig_rd;
    assign cal_rdata = st_ff.cal_rd;
    assign rc_trim_reg = st_ff.trim;

    fscs_addr_split u_split (
        .flash_pc(flash_pc),
        .flash_word_in_page(flash_word_in_page),
        .flash_page_sel(flash_page_sel),
        .eeprom_addr(eeprom_addr),
        .eeprom_byte_in_page(eeprom_byte_in_page),
        .eeprom_page_sel(eeprom_page_sel)
    );

    AST_LOCK_BLOCKS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!st_ff.lock[0] && st_ff.mode != fscs_pkg::FSCS_NORMAL) |=> $stable(st_ff.cells))
        else $error("Fuse cells changed while locked.");
    AST_ACTIVE_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.mode != fscs_pkg::FSCS_NORMAL && (in_ser || in_par))
        |=> ($stable(st_ff.active.low) && $stable(st_ff.active.ext)))
        else $error("Active fuses changed during programming.");
    AST_SERIAL_DL: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.mode == fscs_pkg::FSCS_PROG_SER) |=> $stable(st_ff.cells.high[5]))
        else $error("Serial download fuse written in serial mode.");
    AST_ERASE_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (chip_erase && !fuse_wr) |=> $stable(st_ff.cells))
        else $error("Chip erase changed fuses.");
    AST_PRESERVE_NOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fuse_wr && fuse_sel == 2'h1 && st_ff.lock[0] && (in_ser || in_par)
        && st_ff.mode != fscs_pkg::FSCS_NORMAL) |=> (eeprom_preserve == $past(fuse_wdata[3])))
        else $error("Preserve fuse not effective at once.");
    AST_EXT_ONES: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_ff.cells.ext[7:2] == 6'h3F)
        else $error("Unused extended bits not one.");
    AST_SIG_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rd_addr == 2'h0) |=> (sig_rdata == SIG_BYTE0))
        else $error("Signature byte wrong.");
    AST_POWER_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_ff.pwr_up |=> (st_ff.active == $past(st_ff.cells)))
        else $error("Fuses not latched at power-up.");
    AST_EXIT_APPLY: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_ff.mode != fscs_pkg::FSCS_NORMAL && !in_ser && !in_par)
        |=> (st_ff.active == $past(st_ff.cells)))
        else $error("Fuses not applied on exit.");
endmodule
`default_nettype wire

// ===== shared/fscs_params.svh
// Constants for the fuse and signature configuration store.
`ifndef FSCS_PARAMS_SVH
`define FSCS_PARAMS_SVH
`define FSCS_EXT_RESET 8'hFD
`define FSCS_HIGH_RESET 8'h99
`define FSCS_LOW_RESET 8'hE1
`define FSCS_EXT_UNUSED_MASK 8'hFC
`define FSCS_BIT_LEGACY_COMPAT 1
`define FSCS_BIT_WATCHDOG_ON 0
`define FSCS_BIT_DEBUG_EN 7
`define FSCS_BIT_SCAN_EN 6
`define FSCS_BIT_SERIAL_DL 5
`define FSCS_BIT_OSC_OPT 4
`define FSCS_BIT_EE_PRESERVE 3
`define FSCS_BIT_BOOT_HI 2
`define FSCS_BIT_BOOT_LO 1
`define FSCS_BIT_RESET_VEC 0
`define FSCS_BIT_BO_LEVEL 7
`define FSCS_BIT_BO_ON 6
`define FSCS_SUT_HI 5
`define FSCS_SUT_LO 4
`define FSCS_CKSEL_HI 3
`define FSCS_CKSEL_LO 0
`define FSCS_CKSEL_RC_1MHZ 4'h1
`define FSCS_SIG_ADDR_0 2'h0
`define FSCS_SIG_ADDR_2 2'h2
`define FSCS_CAL_ADDR_1MHZ 2'h0
`define FSCS_SEL_EXT 2'h0
`define FSCS_SEL_HIGH 2'h1
`define FSCS_SEL_LOW 2'h2
`define FSCS_SEL_LOCK 2'h3
`define FSCS_FLASH_WORD_HI 6
`define FSCS_FLASH_PAGE_HI 15
`define FSCS_FLASH_PAGE_LO 7
`define FSCS_EE_BYTE_HI 2
`define FSCS_EE_PAGE_HI 11
`define FSCS_EE_PAGE_LO 3
`endif

// ===== shared/fscs_pkg.sv
// Types for the fuse and signature configuration store.
package fscs_pkg;
    typedef enum logic [1:0] {FSCS_NORMAL, FSCS_PROG_SER, FSCS_PROG_PAR} fscs_mode_t;
    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } fscs_fuse_t;
endpackage

// ===== rtl/fscs_addr_split.sv
// Page geometry split for flash and EEPROM addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fscs_params.svh"
module fscs_addr_split (
    // Flash side
    input wire logic [15:0] flash_pc,
    output logic [6:0] flash_word_in_page,
    output logic [8:0] flash_page_sel,
    // EEPROM side
    input wire logic [11:0] eeprom_addr,
    output logic [2:0] eeprom_byte_in_page,
    output logic [8:0] eeprom_page_sel
);
    assign flash_word_in_page = flash_pc[`FSCS_FLASH_WORD_HI:0];
    assign flash_page_sel = flash_pc[`FSCS_FLASH_PAGE_HI:`FSCS_FLASH_PAGE_LO];
    assign eeprom_byte_in_page = eeprom_addr[`FSCS_EE_BYTE_HI:0];
    assign eeprom_page_sel = eeprom_addr[`FSCS_EE_PAGE_HI:`FSCS_EE_PAGE_LO];
endmodule
`default_nettype wire

// ===== bench/fscs_prog_model.sv
// Programmer model that drives mode pins and fuse, lock and erase strobes.
`timescale 1ns/1ps
`default_nettype none
module fscs_prog_model (
    // Clock
    input wire logic core_clk,
    // Mode pins and strobes
    output logic prog_ser,
    output logic prog_par,
    output logic fuse_wr,
    output logic [1:0] fuse_sel,
    output logic [7:0] fuse_wdata,
    output logic chip_erase,
    output logic lock_wr,
    output logic [7:0] lock_wdata,
    output logic [1:0] rd_addr
);
    initial
    begin
        {prog_ser, prog_par, fuse_wr, chip_erase, lock_wr} = 5'h00;
        {fuse_sel, rd_addr} = 4'h0;
        {fuse_wdata, lock_wdata} = 16'hA55A;
    end
    // Mode change waits out the pin synchroniser before returning.
    task automatic set_mode(input logic ser, input logic par);
        @(posedge core_clk);
        prog_ser <= ser;
        prog_par <= par;
        repeat (4) @(posedge core_clk);
    endtask
    // Kind 0 writes a fuse byte, 1 writes lock bits, 2 erases the chip.
    // fuses first
    task automatic pulse(input logic [1:0] kind, input logic [1:0] sel, input logic [7:0] d);
        @(posedge core_clk);
        fuse_wr <= (kind == 2'h0);
        lock_wr <= (kind == 2'h1);
        chip_erase <= (kind == 2'h2);
        fuse_sel <= sel;
        fuse_wdata <= d;
        lock_wdata <= d;
        @(posedge core_clk);
        {fuse_wr, lock_wr, chip_erase} <= 3'h0;
        fuse_wdata <= ~d;
        lock_wdata <= ~d;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [1:0] sel, input logic [1:0] a);
        @(posedge core_clk);
        fuse_sel <= sel;
        rd_addr <= a;
    endtask
endmodule
`default_nettype wire

// ===== bench/fscs_store_tb.sv
// Self-checking bench for the fuse and signature configuration store.
`timescale 1ns/1ps
`default_nettype none
module fscs_store_tb;
    logic core_clk = 1'b0;
    logic rst_n, trim_wr, look;
    logic [7:0] trim_wdata, lo;
    logic [15:0] flash_pc, obs, pc_r;
    logic [11:0] eeprom_addr, ee_r;
    logic [3:0] obs_sel;
    logic [15:0] exp_q[$];
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    // Identification and trim values are arbitrary.
    logic [7:0] sig_v[4] = '{8'h11, 8'h22, 8'h33, 8'hFF};
    // The 2MHz and 4MHz values stay at the store's own defaults.
    logic [7:0] cal_v[4] = '{8'h44, 8'h81, 8'h82, 8'h77};
    wire logic prog_ser, prog_par, fuse_wr, chip_erase, lock_wr;
    wire logic [1:0] fuse_sel, rd_addr;
    wire logic [7:0] fuse_wdata, lock_wdata;
    logic [7:0] fuse_rdata, sig_rdata, cal_rdata, rc_trim_reg;
    logic legacy_compat_sel, watchdog_forced_on, onchip_debug_en, scan_port_en;
    logic serial_download_en, osc_option, eeprom_preserve, boot_size_hi, boot_size_lo;
    logic reset_vector_sel, brownout_level, brownout_on, startup_sel_hi, startup_sel_lo;
    logic rc_1mhz_sel, sleep_clk_keep, mem_lock_first;
    logic [3:0] clk_source_sel;
    logic [6:0] flash_word_in_page;
    logic [8:0] flash_page_sel, eeprom_page_sel;
    logic [2:0] eeprom_byte_in_page;

    always #2 core_clk = ~core_clk;

    fscs_prog_model prog (.core_clk(core_clk), .prog_ser(prog_ser), .prog_par(prog_par),
        .fuse_wr(fuse_wr), .fuse_sel(fuse_sel), .fuse_wdata(fuse_wdata),
        .chip_erase(chip_erase), .lock_wr(lock_wr), .lock_wdata(lock_wdata), .rd_addr(rd_addr));

    fscs_store #(.SIG_BYTE0(8'h11), .SIG_BYTE1(8'h22), .SIG_BYTE2(8'h33), .CAL_1MHZ(8'h44),
        .CAL_8MHZ(8'h77)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .prog_ser(prog_ser), .prog_par(prog_par),
        .fuse_wr(fuse_wr), .fuse_sel(fuse_sel), .fuse_wdata(fuse_wdata),
        .chip_erase(chip_erase), .lock_wr(lock_wr), .lock_wdata(lock_wdata),
        .rd_addr(rd_addr), .fuse_rdata(fuse_rdata), .sig_rdata(sig_rdata),
        .cal_rdata(cal_rdata), .trim_wr(trim_wr), .trim_wdata(trim_wdata),
        .rc_trim_reg(rc_trim_reg), .legacy_compat_sel(legacy_compat_sel),
        .watchdog_forced_on(watchdog_forced_on), .onchip_debug_en(onchip_debug_en),
        .scan_port_en(scan_port_en), .serial_download_en(serial_download_en),
        .osc_option(osc_option), .eeprom_preserve(eeprom_preserve),
        .boot_size_hi(boot_size_hi), .boot_size_lo(boot_size_lo),
        .reset_vector_sel(reset_vector_sel), .brownout_level(brownout_level),
        .brownout_on(brownout_on), .startup_sel_hi(startup_sel_hi),
        .startup_sel_lo(startup_sel_lo), .clk_source_sel(clk_source_sel),
        .rc_1mhz_sel(rc_1mhz_sel), .sleep_clk_keep(sleep_clk_keep),
        .mem_lock_first(mem_lock_first), .flash_pc(flash_pc), .eeprom_addr(eeprom_addr),
        .flash_word_in_page(flash_word_in_page), .flash_page_sel(flash_page_sel),
        .eeprom_byte_in_page(eeprom_byte_in_page), .eeprom_page_sel(eeprom_page_sel));

    // Observed value picked by the selector raised with each note.
    always_comb
    begin
        case (obs_sel)
            4'h0: obs = {8'h00, fuse_rdata};
            4'h1: obs = {8'h00, sig_rdata};
            4'h2: obs = {8'h00, cal_rdata};
            4'h3: obs = {8'h00, rc_trim_reg};
            4'h4: obs = {8'h00, 6'h3F, legacy_compat_sel, watchdog_forced_on};
            4'h5: obs = {8'h00, onchip_debug_en, scan_port_en, serial_download_en,
                osc_option, eeprom_preserve, boot_size_hi, boot_size_lo, reset_vector_sel};
            4'h6: obs = {8'h00, brownout_level, brownout_on, startup_sel_hi, startup_sel_lo,
                clk_source_sel};
            4'h7: obs = {13'h0000, rc_1mhz_sel, sleep_clk_keep, mem_lock_first};
            4'h8: obs = {flash_page_sel, flash_word_in_page};
            default: obs = {4'h0, eeprom_page_sel, eeprom_byte_in_page};
        endcase
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want)
        begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic note(input logic [3:0] s, input logic [15:0] e);
        @(posedge core_clk);
        obs_sel <= s;
        look <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk);
        look <= 1'b0;
    endtask

    always @(negedge core_clk)
    begin
        if (look === 1'b1 && exp_q.size() > 0)
            check(obs, exp_q.pop_front());
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            close_out();
        end
    end

    initial
    begin
        {rst_n, trim_wr, look, trim_wdata, obs_sel} = 15'h0000;
        flash_pc = 16'h0000;
        eeprom_addr = 12'h000;
        void'($urandom(32'h3D468BCF));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        prog.rd(2'h0, 2'h0);
        note(4'h0, 16'h00FD);
        prog.rd(2'h1, 2'h0);
        note(4'h0, 16'h0099);
        prog.rd(2'h3, 2'h0);
        note(4'h0, 16'h00FF);
        note(4'h4, 16'h00FD);
        note(4'h5, 16'h0099);
        note(4'h6, 16'h00E1);
        note(4'h7, 16'h0004);
        note(4'h3, 16'h0044);
        for (int a = 0; a < 4; a++)
        begin
            prog.rd(2'h0, a[1:0]);
            note(4'h1, {8'h00, sig_v[a]});
            note(4'h2, {8'h00, cal_v[a]});
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge core_clk);
            pc_r = 16'($urandom);
            ee_r = 12'($urandom);
            flash_pc <= pc_r;
            eeprom_addr <= ee_r;
            note(4'h8, pc_r);
            note(4'h9, {4'h0, ee_r});
        end
        // Writes outside programming mode are ignored.
        prog.pulse(2'h0, 2'h2, 8'h00);
        prog.rd(2'h2, 2'h0);
        note(4'h0, 16'h00E1);
        prog.set_mode(1'b0, 1'b1);
        prog.pulse(2'h0, 2'h1, 8'h17);
        note(4'h5, 16'h0091);
        lo = 8'($urandom);
        prog.pulse(2'h0, 2'h2, lo);
        prog.pulse(2'h0, 2'h0, 8'h00);
        note(4'h6, 16'h00E1);
        prog.rd(2'h0, 2'h0);
        note(4'h0, 16'h00FC);
        prog.set_mode(1'b0, 1'b0);
        note(4'h5, 16'h0017);
        note(4'h6, {8'h00, lo});
        note(4'h4, 16'h00FC);
        note(4'h7, {13'h0000, lo[3:0] == 4'h1, 2'b10});
        // Serial session keeps the download bit and honours the lock.
        prog.set_mode(1'b1, 1'b0);
        prog.pulse(2'h0, 2'h1, 8'h3F);
        prog.rd(2'h1, 2'h0);
        note(4'h0, 16'h001F);
        prog.pulse(2'h1, 2'h0, 8'hFE);
        note(4'h7, {13'h0000, lo[3:0] == 4'h1, 2'b11});
        prog.pulse(2'h0, 2'h2, ~lo);
        prog.rd(2'h2, 2'h2);
        note(4'h0, {8'h00, lo});
        note(4'h1, 16'h0033);
        prog.pulse(2'h2, 2'h0, 8'h00);
        prog.rd(2'h3, 2'h0);
        note(4'h0, 16'h00FF);
        prog.rd(2'h2, 2'h0);
        note(4'h0, {8'h00, lo});
        prog.set_mode(1'b0, 1'b0);
        @(posedge core_clk);
        trim_wr <= 1'b1;
        trim_wdata <= 8'h4C;
        @(posedge core_clk);
        trim_wr <= 1'b0;
        note(4'h3, 16'h004C);
        // A second reset reloads the trim and the active copy.
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        note(4'h3, 16'h0044);
        note(4'h5, 16'h0099);
        repeat (3) @(posedge core_clk);
        close_out();
    end
endmodule
`default_nettype wire
